// *** src/mcuid_pkg.sv ***
// Constants, opcodes and types shared by the instruction decoder files.
package mcuid_pkg;
  localparam int IW  = 14;
  localparam int DW  = 8;
  localparam int PCW = 12;
  localparam int SPW = 3;
  localparam int FAW = 7;
  localparam int RAW = 6;
  localparam int THW = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_PC   = 8'h0c;
  localparam logic [7:0] OFF_FIDX = 8'h10;
  localparam logic [7:0] OFF_FDAT = 8'h14;
  localparam logic [7:0] OFF_TBLH = 8'h18;
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_IRQA = 1;
  localparam int ST_CY  = 0;
  localparam int ST_HC  = 1;
  localparam int ST_ZR  = 2;
  localparam int ST_WDX = 3;
  localparam int ST_SLE = 4;
  localparam int ST_IRQ = 5;
  localparam int ST_SLP = 6;
  localparam logic [IW-1:0] w_nop        = 14'h0000;
  localparam logic [IW-1:0] w_sleep      = 14'h0003;
  localparam logic [IW-1:0] w_kick       = 14'h0004;
  localparam logic [IW-1:0] w_ret        = 14'h0040;
  localparam logic [IW-1:0] w_return_from_irq_op       = 14'h0060;
  localparam logic [IW-1:0] w_tab_low    = 14'h0050;
  localparam logic [IW-1:0] w_tab_high   = 14'h0058;
  localparam logic [IW-1:0] w_zero_acc   = 14'h0140;
  localparam logic [5:0] sub_acc_from_file_op = 6'h02;
  localparam logic [5:0] add_acc_file_op      = 6'h07;
  localparam logic [PCW-1:0] PC_RST   = 12'h000;
  localparam logic [DW-1:0]  BYTE_RST = 8'h00;
  typedef enum logic [3:0] {
    ALU_PASS = 4'h0, ALU_ADD = 4'h1, ALU_SUB = 4'h2, ALU_AND = 4'h3,
    ALU_OR = 4'h4, ALU_XOR = 4'h5, ALU_COM = 4'h6, ALU_INC = 4'h7,
    ALU_DEC = 4'h8, ALU_RLF = 4'h9, ALU_RRF = 4'ha, ALU_SWAP = 4'hb
  } mcuid_alu_type;
  typedef enum logic [2:0] {
    CS_RUN = 3'b001, CS_TABLE = 3'b010, CS_SLEEP = 3'b100
  } mcuid_state_type;
endpackage

// *** src/mcuid_alu_if.sv ***
// Operand and result bundle between the core and its arithmetic unit.
`timescale 1ns/1ps
interface mcuid_alu_if;
  import mcuid_pkg::*;
  mcuid_alu_type op;
  logic [DW-1:0] a;
  logic [DW-1:0] b;
  logic [DW-1:0] y;
  logic          cin;
  logic          cout;
  logic          hc;
  logic          zero;
  modport core (output op, a, b, cin, input y, cout, hc, zero);
  modport unit (input op, a, b, cin, output y, cout, hc, zero);
endinterface

// *** src/mcuid_alu.sv ***
// Arithmetic and logic unit of the instruction decoder.
`timescale 1ns/1ps
module mcuid_alu
  import mcuid_pkg::*;
(
  mcuid_alu_if.unit bus
);
  logic [DW:0] sum;
  logic [4:0]  nib;

  always_comb begin
    sum = {1'b0, bus.a} + {1'b0, bus.b};
    nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
    bus.y = bus.a;
    bus.cout = bus.cin;
    bus.hc = 1'b0;
    case (bus.op)
      ALU_ADD: begin
        bus.y = sum[DW-1:0];
        bus.cout = sum[DW];
        bus.hc = nib[4];
      end
      ALU_SUB: begin
        sum = {1'b0, bus.a} - {1'b0, bus.b};
        nib = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]};
        bus.y = sum[DW-1:0];
        bus.cout = ~sum[DW];
        bus.hc = ~nib[4];
      end
      ALU_AND:  bus.y = bus.a & bus.b;
      ALU_OR:   bus.y = bus.a | bus.b;
      ALU_XOR:  bus.y = bus.a ^ bus.b;
      ALU_COM:  bus.y = ~bus.a;
      ALU_INC:  bus.y = bus.a + 8'h01;
      ALU_DEC:  bus.y = bus.a - 8'h01;
      ALU_RLF: begin
        bus.y = {bus.a[6:0], bus.cin};
        bus.cout = bus.a[7];
      end
      ALU_RRF: begin
        bus.y = {bus.cin, bus.a[7:1]};
        bus.cout = bus.a[0];
      end
      ALU_SWAP: bus.y = {bus.a[3:0], bus.a[7:4]};
      default:  bus.y = bus.a;
    endcase
    bus.zero = (bus.y == 8'h00);
  end
endmodule

// *** src/mcuid_core.sv ***
// Instruction decoder and executor of the 8-bit core with its APB register slave.
// What this block does
// - Takes 14-bit words and splits them into opcode and operand fields.
// - Byte results go to accumulator when destination bit is 0, else to the file.
// - Byte words: six-bit opcode, destination bit, seven-bit file address.
// - File add and subtract update carry, half carry, zero; carry is inverted borrow.
// - Half carry is low-nibble carry or inverted low-nibble borrow.
// - Literal add and literal-minus-accumulator write accumulator, update three flags, one cycle.
// - Count-and-skip ops write destination, keep flags, skip next when result is zero.
// - Rotates move operand one place through carry and touch only carry.
// - Bit clear and set force one bit, one cycle, no flags.
// - Bit tests skip next word when the bit is clear or set.
// - Literal logic ops update zero; load literal keeps flags.
// - Call and goto take twelve-bit target, two cycles; call pushes return address.
// - Returns reload program counter from stack head; literal return loads accumulator.
// - Sleep stops execution and updates watchdog expiry and sleep entry bits.
// - Watchdog kick pulses the clear and updates both status bits.
// - Table reads put high or low program word part in accumulator, two cycles.
// - Plane store writes accumulator into second plane at six-bit address.
// - Store and load to accumulator move data without flags; load to file updates zero; clear file zeroes and sets zero.
// - Bit ops reach file addresses 00h to 3Fh, bit positions 0 to 7.
`timescale 1ns/1ps
module mcuid_core
  import mcuid_pkg::*;
(
  input  logic           pclk,
  input  logic           presetn,
  input  logic           psel,
  input  logic           penable,
  input  logic           pwrite,
  input  logic [7:0]     paddr,
  input  logic [31:0]    pwdata,
  output logic [31:0]    prdata,
  output logic           pready,
  output logic           pslverr,
  output logic [PCW-1:0] prog_addr,
  input  logic [IW-1:0]  prog_word,
  input  logic           wake_event,
  input  logic           watchdog_timeout,
  output logic           watchdog_clear,
  output logic           sleeping
);
  mcuid_alu_if alu ();
  mcuid_alu u_alu (.bus(alu.unit));

  mcuid_state_type state_reg;
  logic [IW-1:0]  instr_reg;
  logic           flush_reg;
  logic [PCW-1:0] prog_addr_reg;
  logic [PCW-1:0] resume_reg;
  logic           tabsel_reg;
  logic [DW-1:0]  acc_reg;
  logic           c_reg;
  logic           hc_reg;
  logic           z_reg;
  logic           wdx_reg;
  logic           sle_reg;
  logic           gia_reg;
  logic           wdt_clear_reg;
  logic [DW-1:0]  file_reg [0:(1<<FAW)-1];
  logic [DW-1:0]  plane_reg [0:(1<<RAW)-1];
  logic [PCW-1:0] stack_reg [0:(1<<SPW)-1];
  logic [SPW-1:0] sp_reg;
  logic           run_reg;
  logic [FAW-1:0] fidx_reg;
  logic [THW-1:0] tblh_reg;
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;

  logic [IW-1:0]  w;
  logic [PCW-1:0] tgt;
  logic [PCW-1:0] stack_head;
  logic [FAW-1:0] fa;
  logic [DW-1:0]  fval;
  logic [DW-1:0]  mask;
  logic [DW-1:0]  wd;
  logic           ex;
  logic           acc_we;
  logic           file_we;
  logic           plane_we;
  logic           upd_c;
  logic           upd_hc;
  logic           upd_z;
  logic           z_val;
  logic           skip;
  logic           jump;
  logic           push;
  logic           pop;
  logic           irq_set;
  logic           go_sleep;
  logic           kick;
  logic           tab;
  logic           apb_setup;
  logic           apb_wr;
  logic [31:0]    rd_val;

  function automatic logic [DW-1:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  function automatic mcuid_alu_type byte_alu(input logic [3:0] op);
    case (op)
      4'h2:         byte_alu = ALU_SUB;
      4'h3, 4'hb:   byte_alu = ALU_DEC;
      4'h4:         byte_alu = ALU_OR;
      4'h5:         byte_alu = ALU_AND;
      4'h6:         byte_alu = ALU_XOR;
      4'h7:         byte_alu = ALU_ADD;
      4'h9:         byte_alu = ALU_COM;
      4'ha, 4'hf:   byte_alu = ALU_INC;
      4'hc:         byte_alu = ALU_RRF;
      4'hd:         byte_alu = ALU_RLF;
      4'he:         byte_alu = ALU_SWAP;
      default:      byte_alu = ALU_PASS;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_CTRL) || (a == OFF_ACC) || (a == OFF_STAT) || (a == OFF_PC) ||
              (a == OFF_FIDX) || (a == OFF_FDAT) || (a == OFF_TBLH);
  endfunction

  assign alu.b = acc_reg;
  assign alu.cin = c_reg;
  assign stack_head = stack_reg[sp_reg - 3'd1];
  assign tgt = w[PCW-1:0];

  // A flushed slot executes as a no-operation word.
  always_comb begin
    w = flush_reg ? w_nop : instr_reg;
    ex = run_reg && (state_reg == CS_RUN);
    fa = (w[13:12] == 2'b01) ? {1'b0, w[5:0]} : w[FAW-1:0];
    fval = file_reg[fa];
    mask = bit_mask(w[8:6]);
    alu.op = ALU_PASS;
    alu.a = fval;
    wd = alu.y;
    z_val = alu.zero;
    {acc_we, file_we, plane_we, upd_c, upd_hc, upd_z} = 6'h00;
    {skip, jump, push, pop, irq_set, go_sleep, kick, tab} = 8'h00;
    if (ex) begin
      if (w == w_sleep) begin
        go_sleep = 1'b1;
      end else if (w == w_kick) begin
        kick = 1'b1;
      end else if (w == w_ret || w == w_return_from_irq_op) begin
        pop = 1'b1;
        irq_set = (w == w_return_from_irq_op);
      end else if (w == w_tab_low || w == w_tab_high) begin
        tab = 1'b1;
      end else if (w[13]) begin
        jump = 1'b1;
        push = ~w[12];
      end else if (w[13:12] == 2'b00) begin
        case (w[11:8])
          4'h0: begin
            if (w[7]) begin
              file_we = 1'b1;
              wd = acc_reg;
            end else if (w[6] == 1'b0 && w[5:0] != 6'h00) begin
              plane_we = 1'b1;
            end
          end
          4'h1: begin
            if (w[7] || w == w_zero_acc) begin
              file_we = w[7];
              acc_we = ~w[7];
              wd = 8'h00;
              upd_z = 1'b1;
              z_val = 1'b1;
            end
          end
          default: begin
            alu.op = byte_alu(w[11:8]);
            acc_we = ~w[7];
            file_we = w[7];
            case (w[11:8])
              4'h2, 4'h7: {upd_c, upd_hc, upd_z} = 3'b111;
              4'hc, 4'hd: upd_c = 1'b1;
              4'hb, 4'hf: skip = alu.zero;
              4'h8: begin
                file_we = 1'b0;
                upd_z = w[7];
              end
              default: upd_z = (w[11:8] != 4'he);
            endcase
          end
        endcase
      end else if (w[11] == 1'b0) begin
        case (w[10:9])
          2'b00: begin
            file_we = 1'b1;
            wd = fval & ~mask;
          end
          2'b01: begin
            file_we = 1'b1;
            wd = fval | mask;
          end
          2'b10:   skip = ~|(fval & mask);
          default: skip = |(fval & mask);
        endcase
      end else begin
        alu.a = w[7:0];
        case (w[10:8])
          3'h0: begin
            acc_we = 1'b1;
            wd = w[7:0];
            pop = 1'b1;
          end
          3'h1: begin
            acc_we = 1'b1;
            wd = w[7:0];
          end
          3'h2, 3'h3, 3'h7: begin
            alu.op = (w[10:8] == 3'h2) ? ALU_OR : (w[10:8] == 3'h3) ? ALU_AND : ALU_XOR;
            acc_we = 1'b1;
            upd_z = 1'b1;
          end
          3'h4, 3'h5: begin
            alu.op = w[8] ? ALU_SUB : ALU_ADD;
            acc_we = 1'b1;
            {upd_c, upd_hc, upd_z} = 3'b111;
          end
          default: acc_we = 1'b0;
        endcase
      end
    end
  end

  // Sleep still advances the fetch address so that the word held across sleep resumes in order.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CS_RUN;
      instr_reg <= w_nop;
      flush_reg <= 1'b0;
      prog_addr_reg <= PC_RST;
      resume_reg <= PC_RST;
      tabsel_reg <= 1'b0;
    end else if (run_reg) begin
      case (state_reg)
        CS_RUN: begin
          instr_reg <= prog_word;
          flush_reg <= jump | skip | pop;
          if (jump) begin
            prog_addr_reg <= tgt;
          end else if (pop) begin
            prog_addr_reg <= stack_head;
          end else if (tab) begin
            prog_addr_reg <= {tblh_reg, acc_reg};
            resume_reg <= prog_addr_reg + 12'h001;
            tabsel_reg <= w[3];
            state_reg <= CS_TABLE;
          end else begin
            prog_addr_reg <= prog_addr_reg + 12'h001;
          end
          if (go_sleep) begin
            state_reg <= CS_SLEEP;
          end
        end
        CS_TABLE: begin
          prog_addr_reg <= resume_reg;
          state_reg <= CS_RUN;
        end
        CS_SLEEP: begin
          if (wake_event || watchdog_timeout) begin
            state_reg <= CS_RUN;
          end
        end
        default: state_reg <= CS_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= BYTE_RST;
    end else if (acc_we) begin
      acc_reg <= wd;
    end else if (run_reg && state_reg == CS_TABLE) begin
      acc_reg <= tabsel_reg ? {2'b00, prog_word[13:8]} : prog_word[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_reg <= 1'b0;
      hc_reg <= 1'b0;
      z_reg <= 1'b0;
    end else begin
      if (upd_c) begin
        c_reg <= alu.cout;
      end
      if (upd_hc) begin
        hc_reg <= alu.hc;
      end
      if (upd_z) begin
        z_reg <= z_val;
      end
    end
  end

  // An expiry arriving with a kick or sleep still sets the expiry bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdx_reg <= 1'b0;
      sle_reg <= 1'b0;
      wdt_clear_reg <= 1'b0;
      gia_reg <= 1'b0;
    end else begin
      wdt_clear_reg <= kick;
      if (watchdog_timeout) begin
        wdx_reg <= 1'b1;
      end else if (go_sleep || kick) begin
        wdx_reg <= 1'b0;
      end
      if (go_sleep) begin
        sle_reg <= 1'b1;
      end else if (kick) begin
        sle_reg <= 1'b0;
      end
      if (irq_set) begin
        gia_reg <= 1'b1;
      end else if (apb_wr && paddr == OFF_CTRL) begin
        gia_reg <= pwdata[CTRL_IRQA];
      end
    end
  end

  // The stack wraps silently on overflow; software must bound its call depth.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_reg <= '0;
      for (int i = 0; i < (1 << SPW); i++) begin
        stack_reg[i] <= PC_RST;
      end
    end else if (push) begin
      stack_reg[sp_reg] <= prog_addr_reg;
      sp_reg <= sp_reg + 3'd1;
    end else if (pop) begin
      sp_reg <= sp_reg - 3'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < (1 << FAW); i++) begin
        file_reg[i] <= BYTE_RST;
      end
    end else if (file_we) begin
      file_reg[fa] <= wd;
    end else if (apb_wr && paddr == OFF_FDAT) begin
      file_reg[fidx_reg] <= pwdata[DW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < (1 << RAW); i++) begin
        plane_reg[i] <= BYTE_RST;
      end
    end else if (plane_we) begin
      plane_reg[w[RAW-1:0]] <= acc_reg;
    end
  end

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready_reg && pwrite;

  always_comb begin
    case (paddr)
      OFF_CTRL: rd_val = {30'h0, gia_reg, run_reg};
      OFF_ACC:  rd_val = {24'h0, acc_reg};
      OFF_STAT: rd_val = {25'h0, state_reg == CS_SLEEP, gia_reg, sle_reg, wdx_reg, z_reg, hc_reg, c_reg};
      OFF_PC:   rd_val = {20'h0, prog_addr_reg};
      OFF_FIDX: rd_val = {25'h0, fidx_reg};
      OFF_FDAT: rd_val = {24'h0, file_reg[fidx_reg]};
      OFF_TBLH: rd_val = {28'h0, tblh_reg};
      default:  rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg <= 1'b0;
      fidx_reg <= '0;
      tblh_reg <= '0;
    end else if (apb_wr) begin
      case (paddr)
        OFF_CTRL: run_reg <= pwdata[CTRL_RUN];
        OFF_FIDX: fidx_reg <= pwdata[FAW-1:0];
        OFF_TBLH: tblh_reg <= pwdata[THW-1:0];
        default:  run_reg <= run_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_setup;
      pslverr_reg <= apb_setup && !reg_hit(paddr);
      if (apb_setup) begin
        prdata_reg <= pwrite ? 32'h0 : rd_val;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prog_addr = prog_addr_reg;
  assign watchdog_clear = wdt_clear_reg;
  assign sleeping = state_reg[2];

  property p_dest_acc;
    @(posedge pclk) disable iff (!presetn)
      (ex && w[13:8] == add_acc_file_op && !w[7]) |=> (acc_reg == $past(wd));
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("byte result missed accumulator");

  property p_sub_carry;
    @(posedge pclk) disable iff (!presetn)
      (ex && w[13:8] == sub_acc_from_file_op) |=> (c_reg == ($past(fval) >= $past(acc_reg)));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry is not inverted borrow");

  property p_skip_flags;
    @(posedge pclk) disable iff (!presetn)
      (ex && skip && w[13:12] == 2'b00) |=> ($stable({c_reg, hc_reg, z_reg}) && flush_reg);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("count skip changed flags or missed skip");

  property p_call;
    @(posedge pclk) disable iff (!presetn)
      (ex && push) |=> (sp_reg == $past(sp_reg) + 3'd1 && prog_addr_reg == $past(tgt));
  endproperty
  a_call: assert property (p_call) else $error("call did not push and jump");

  property p_ret;
    @(posedge pclk) disable iff (!presetn)
      (ex && pop) |=> (prog_addr_reg == $past(stack_head));
  endproperty
  a_ret: assert property (p_ret) else $error("return did not reload from stack head");

  property p_return_from_irq_op;
    @(posedge pclk) disable iff (!presetn)
      (ex && w == w_return_from_irq_op) |=> gia_reg;
  endproperty
  a_return_from_irq_op: assert property (p_return_from_irq_op) else $error("interrupt return left allow flag clear");

  property p_sleep;
    @(posedge pclk) disable iff (!presetn)
      (ex && go_sleep) |=> (sleeping && sle_reg);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

  property p_kick;
    @(posedge pclk) disable iff (!presetn)
      (ex && kick && !watchdog_timeout) |=> (watchdog_clear && !wdx_reg && !sle_reg);
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog kick not applied");

  property p_table;
    @(posedge pclk) disable iff (!presetn)
      (ex && tab && run_reg) |=> (state_reg == CS_TABLE) ##1 (state_reg == CS_RUN || !run_reg);
  endproperty
  a_table: assert property (p_table) else $error("table read not two cycles");

  property p_flush;
    @(posedge pclk) disable iff (!presetn)
      (ex && (jump || pop)) |=> (flush_reg && !acc_we && !file_we);
  endproperty
  a_flush: assert property (p_flush) else $error("prefetched word not discarded");
endmodule

// *** bench/mcuid_prog_rom.sv ***
// Program memory model that answers the fetch address without delay.
`timescale 1ns/1ps
module mcuid_prog_rom
  import mcuid_pkg::*;
(
  input  wire logic [PCW-1:0] prog_addr,
  output logic      [IW-1:0]  prog_word
);
  logic [IW-1:0] mem [0:(1<<PCW)-1];

  // The read is asynchronous because the core samples the word in the cycle that it drives the address.
  assign prog_word = mem[prog_addr];
endmodule

// *** bench/testbench.sv ***
// Self-checking testbench of the instruction decoder with its program memory model.
`timescale 1ns/1ps
module testbench;
  import mcuid_pkg::*;
  logic           pclk             = 1'b0;
  logic           presetn          = 1'b0;
  logic           psel             = 1'b0;
  logic           penable          = 1'b0;
  logic           pwrite           = 1'b0;
  logic [7:0]     paddr            = 8'h00;
  logic [31:0]    pwdata           = 32'h0;
  logic           wake_event       = 1'b0;
  logic           watchdog_timeout = 1'b0;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic [PCW-1:0] prog_addr;
  logic [IW-1:0]  prog_word;
  logic           watchdog_clear;
  logic           sleeping;
  logic [31:0]    q;
  logic           e;
  int             errors    = 0;
  int             cmp_count = 0;
  int             kicks     = 0;

  mcuid_core u_mcuid_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .prog_word(prog_word), .wake_event(wake_event),
    .watchdog_timeout(watchdog_timeout), .watchdog_clear(watchdog_clear), .sleeping(sleeping));
  mcuid_prog_rom u_mcuid_prog_rom (.prog_addr(prog_addr), .prog_word(prog_word));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (watchdog_clear === 1'b1) begin
      kicks <= kicks + 1;
    end
  end

  task automatic give_verdict;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  // The request is held until pready is seen high or 20 more cycles pass, so a slow answer is tolerated as well.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      errors++;
      $display("mismatch pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask

  task automatic prep;
    for (int i = 0; i < (1 << PCW); i++) begin
      u_mcuid_prog_rom.mem[i] = w_nop;
    end
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic put(input int a, input logic [IW-1:0] w);
    u_mcuid_prog_rom.mem[a] = w;
  endtask

  task automatic run(input int n);
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (n) @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h0);
  endtask

  task automatic t_literal;
    prep();
    put(0, {6'h19, 8'h0f});
    put(1, {6'h1c, 8'h01});
    run(10);
    rd_chk("acc", OFF_ACC, 32'h10);
    rd_chk("status", OFF_STAT, 32'h1 << ST_HC);
    prep();
    put(0, {6'h19, 8'h01});
    put(1, {6'h1d, 8'h01});
    run(10);
    rd_chk("acc", OFF_ACC, 32'h0);
    rd_chk("status", OFF_STAT, (32'h1 << ST_CY) | (32'h1 << ST_HC) | (32'h1 << ST_ZR));
  endtask

  task automatic t_file;
    prep();
    apb(1'b1, OFF_FIDX, 32'h5);
    apb(1'b1, OFF_FDAT, 32'h3);
    put(0, {6'h19, 8'hff});
    put(1, {add_acc_file_op, 1'b1, 7'h05});
    put(2, {sub_acc_from_file_op, 1'b0, 7'h05});
    run(10);
    rd_chk("file", OFF_FDAT, 32'h02);
    rd_chk("acc", OFF_ACC, 32'h03);
    rd_chk("status", OFF_STAT, 32'h0);
  endtask

  // The discarded and skipped words would overwrite the accumulator if they ran.
  task automatic t_flow;
    prep();
    put(0, {6'h19, 8'h00});
    put(1, {2'b11, 12'h003});
    put(2, {6'h19, 8'haa});
    put(3, {7'h01, 7'h20});
    put(4, {2'b01, 3'b001, 3'd0, 6'h20});
    put(5, {2'b01, 3'b011, 3'd0, 6'h20});
    put(6, {6'h19, 8'hbb});
    put(7, {6'h0b, 1'b0, 7'h20});
    put(8, {6'h19, 8'hbb});
    put(9, {6'h1a, 8'h40});
    run(20);
    rd_chk("acc", OFF_ACC, 32'h40);
    rd_chk("status", OFF_STAT, 32'h0);
    apb(1'b1, OFF_FIDX, 32'h20);
    rd_chk("file", OFF_FDAT, 32'h01);
    rd_chk("unmapped", 8'h1c, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
  endtask

  task automatic t_sleep;
    prep();
    put(0, w_kick);
    put(1, w_sleep);
    put(2, {6'h19, 8'h77});
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (10) @(posedge pclk);
    chk("sleeping", 32'h1, {31'h0, sleeping});
    chk("kicks", 32'h1, 32'(kicks));
    rd_chk("status", OFF_STAT, (32'h1 << ST_SLE) | (32'h1 << ST_SLP));
    rd_chk("acc", OFF_ACC, 32'h0);
    @(posedge pclk);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h0);
    rd_chk("acc", OFF_ACC, 32'h77);
    rd_chk("status", OFF_STAT, (32'h1 << ST_WDX) | (32'h1 << ST_SLE));
  endtask

  // Each return and table read feeds the next address, so one wrong step shows in the final values.
  task automatic t_call;
    prep();
    apb(1'b1, OFF_TBLH, 32'h1);
    put(0, {6'h19, 8'h05});
    put(1, {2'b10, 12'h010});
    put(16, w_return_from_irq_op);
    put(2, w_tab_high);
    put(3, {7'h01, 7'h30});
    put(4, {2'b10, 12'h020});
    put(32, {6'h18, 8'h3c});
    put(5, w_tab_low);
    put(6, w_sleep);
    put(7, {6'h19, 8'h99});
    put(12'h105, 14'h2a5b);
    put(12'h13c, 14'h1234);
    apb(1'b1, OFF_CTRL, 32'h1);
    repeat (30) @(posedge pclk);
    rd_chk("acc", OFF_ACC, 32'h34);
    rd_chk("pc", OFF_PC, 32'h8);
    rd_chk("status", OFF_STAT, (32'h1 << ST_IRQ) | (32'h1 << ST_SLE) | (32'h1 << ST_SLP));
    apb(1'b1, OFF_FIDX, 32'h30);
    rd_chk("file", OFF_FDAT, 32'h2a);
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h0);
    rd_chk("acc", OFF_ACC, 32'h99);
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    $display("mismatch watchdog expected end seen hang");
    give_verdict();
  end

  initial begin
    t_literal();
    t_file();
    t_flow();
    t_sleep();
    t_call();
    give_verdict();
  end
endmodule
